/* File: hdl/uart_channel_core.sv */
// Operation
// R1: A holding write starts sending; byte moves to shifter, buffer-empty sets.
// R2: Frame is start, data LSB first, optional parity, stop bits; busy set.
// R3: After stop, if holding empty, clear transmit busy and set done flag.
// R4: Software writes next byte only when buffer-empty flag is 1.
// R5: Low on input is start bit; set receive busy and shift in data.
// R6: At stop sample clear receive busy and move byte into the FIFO.
// R7: Two-entry FIFO; first byte sets one-full, second sets two-full.
// R8: Software may read twice when two-full, else once per one-full.
// R9: Infrared mode uses modulator and demodulator; control unchanged.
// R10: Infrared low bit becomes inverted 3/16 pulse; optional extra invert.
// R11: Infrared receive pulses stretched to full bit; optional input invert.
// R12: Far infrared source keeps low pulses at least 3 operating cycles.
// R13: Stop sampled 0 is framing error; byte stored, flag when readable.
// R14: Error flag sets on store if FIFO empty, else on first-entry read.
// R15: Parity mismatch stores byte and sets parity flag like framing flag.
// R16: Byte arriving with FIFO full is dropped and overrun flag set.
// R17: Done and overrun flags clear by writing 1 or software reset.
// R18: Framing and parity flags clear by write 1, reset or reading byte.
// R19: Interrupt asserted while any flag is set with its enable bit.
// R20: Buffer-empty flag resets to 1 so enabling it interrupts at once.
// R21: Software configures, soft-resets, enables, clears flags, enables irqs.
// R22: Format: 7/8 data bits, 1/2 stop bits, parity even, odd or none.
// R23: Bit time is (divisor+1)*16+fraction operating clock cycles.
// R24: Receive data reads return the oldest FIFO byte first.
// R25: Soft-reset bit resets control and flags, reads 1 then self-clears; here it resets flags and state but not control registers.
// R26: Receiver samples bits at mid-period and confirms start at mid-bit.
// R27: While disabled, transmitter and receiver idle, output high, no flags.
`timescale 1ns/1ps
`include "uart_channel_regs.svh"

module uart_channel_core (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             irq
);

  // --------------------------------------------------------------------
  // Registers and shared state
  // --------------------------------------------------------------------
  logic [8:0]                    clock_select_reg;
  uart_channel_pkg::frame_cfg_t  frame_config_reg;
  logic [11:0]                   bit_rate_reg;
  logic                          channel_enable;
  logic                          soft_reset_bit;
  logic [7:0]                    tx_holding_reg;
  logic [6:0]                    irq_enable_reg;
  logic                          tx_buffer_empty_flag;
  logic                          tx_done_flag;
  logic                          framing_err_flag;
  logic                          parity_err_flag;
  logic                          overrun_err_flag;
  logic                          tx_busy;
  logic                          rx_busy;
  uart_channel_pkg::rx_entry_t   fifo [2];
  logic [1:0]                    fifo_count;
  logic [2:0]                    div_cnt;
  logic [2:0]                    div_mask;
  logic                          op_tick;
  logic [12:0]                   bit_len;
  logic [12:0]                   rx_mid;
  logic [14:0]                   len_x3;
  logic [12:0]                   ir_pulse_len;
  logic                          srst;
  logic                          access;
  logic                          wr_done;
  logic                          rd_done;
  logic                          tx_write;
  logic                          rx_pop;
  logic                          flag_write;
  logic [31:0]                   next_prdata;
  logic [9:0]                    flag_view;
  logic                          rx_store;
  logic                          rx_fe;
  logic                          rx_pe;
  logic [7:0]                    rx_shift;

  assign access  = psel & penable & pready;
  assign wr_done = ce & access & pwrite;
  assign rd_done = ce & access & ~pwrite;
  assign tx_write   = wr_done & (paddr == `TX_HOLDING_OFS);
  assign flag_write = wr_done & (paddr == `FLAG_OFS);
  assign rx_pop     = rd_done & (paddr == `RX_FIFO_OFS) & (fifo_count != 2'd0);
  assign srst = rst | soft_reset_bit;

  // --------------------------------------------------------------------
  // Operating clock divider and bit timing
  // --------------------------------------------------------------------
  assign div_mask = 3'((4'h1 << clock_select_reg[5:4]) - 4'h1);
  assign op_tick  = ce & channel_enable & ((div_cnt & div_mask) == div_mask);
  // Bit time in operating clocks                      see R23
  assign bit_len = {1'b0, 8'(bit_rate_reg[7:0]), 4'h0} + 13'h010
                   + 13'(bit_rate_reg[11:8]);
  assign rx_mid = bit_len >> 1;
  assign len_x3 = {2'b00, bit_len} + {1'b0, bit_len, 1'b0};
  assign ir_pulse_len = {2'b00, len_x3[14:4]} + 13'(len_x3[3:0] != 4'h0);

  always_ff @(posedge clk) begin
    if (rst || !channel_enable)
      div_cnt <= 3'h0;
    else if (ce)
      div_cnt <= div_cnt + 3'h1;
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  always_comb begin
    flag_view = {rx_busy, tx_busy, 1'b0, tx_done_flag, framing_err_flag,
                 parity_err_flag, overrun_err_flag, fifo_count == 2'd2,
                 fifo_count != 2'd0, tx_buffer_empty_flag};
    case (paddr)
      `CLOCK_SELECT_OFS: next_prdata = {23'h0, clock_select_reg};
      `FRAME_CONFIG_OFS: next_prdata = {22'h0, frame_config_reg};
      `BIT_RATE_OFS:     next_prdata = {20'h0, bit_rate_reg};
      `CHANNEL_CTRL_OFS: next_prdata = {30'h0, soft_reset_bit, channel_enable};
      `TX_HOLDING_OFS:   next_prdata = {24'h0, tx_holding_reg};
      `RX_FIFO_OFS:      next_prdata = {24'h0, fifo[0].data};  // see R24
      `FLAG_OFS:         next_prdata = {22'h0, flag_view};
      `IRQ_ENABLE_OFS:   next_prdata = {25'h0, irq_enable_reg};
      default:           next_prdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0;
      pslverr <= psel & penable & ~pready & (paddr[1:0] != 2'b00 ||
                 paddr > `IRQ_ENABLE_OFS);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clock_select_reg <= `CLOCK_SELECT_RST;
      frame_config_reg <= `FRAME_CONFIG_RST;
      bit_rate_reg     <= `BIT_RATE_RST;
      channel_enable   <= 1'b0;
      irq_enable_reg   <= 7'h00;
    end else if (wr_done) begin
      case (paddr)
        `CLOCK_SELECT_OFS: if (!channel_enable) clock_select_reg <=
                             pwdata[8:0] & 9'h133;
        `FRAME_CONFIG_OFS: if (!channel_enable) frame_config_reg <=
                             pwdata[9:0] & 10'h37f;
        `BIT_RATE_OFS:     if (!channel_enable) bit_rate_reg <= pwdata[11:0];
        `CHANNEL_CTRL_OFS: channel_enable <= pwdata[`CHANNEL_ENABLE_BIT];
        `IRQ_ENABLE_OFS:   irq_enable_reg <= pwdata[6:0];
        default: ;
      endcase
    end
  end

  // Self-clearing software reset, reads 1 for one cycle      see R25
  always_ff @(posedge clk) begin
    if (rst)
      soft_reset_bit <= 1'b0;
    else if (ce)
      soft_reset_bit <= wr_done & (paddr == `CHANNEL_CTRL_OFS) &
                        pwdata[`SOFT_RESET_BIT];
  end

  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  uart_channel_pkg::tx_state_t tx_state;
  logic [7:0]  tx_shift;
  logic [12:0] tx_cnt;
  logic [2:0]  tx_bit;
  logic        tx_stop2;
  logic        tx_level;
  logic        tx_bit_end;
  logic        tx_load;
  logic        tx_parity;

  assign tx_bit_end = op_tick & (tx_cnt == bit_len - 13'h1);
  assign tx_load = ~tx_buffer_empty_flag & op_tick &
                   (tx_state == uart_channel_pkg::TX_IDLE ||
                    (tx_state == uart_channel_pkg::TX_STOP && tx_bit_end &&
                     (!frame_config_reg.stop_bits || tx_stop2)));
  assign tx_parity = ^(tx_shift & {frame_config_reg.char_length, 7'h7f}) ^
                     frame_config_reg.parity_odd;

  always_ff @(posedge clk) begin
    if (rst)
      tx_holding_reg <= 8'h00;
    else if (tx_write)
      tx_holding_reg <= pwdata[7:0];
  end

  // Buffer-empty flag: written byte moves on, flag returns to 1  see R1, R20
  always_ff @(posedge clk) begin
    if (srst)
      tx_buffer_empty_flag <= `TX_BUFFER_EMPTY_RST;
    else if (tx_load)
      tx_buffer_empty_flag <= 1'b1;
    else if (tx_write)
      tx_buffer_empty_flag <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst || !channel_enable) begin  // see R27
      tx_state <= uart_channel_pkg::TX_IDLE;
      tx_shift <= 8'h00;
      tx_cnt   <= 13'h0;
      tx_bit   <= 3'h0;
      tx_stop2 <= 1'b0;
      tx_busy  <= 1'b0;
    end else if (op_tick) begin
      tx_cnt <= tx_bit_end ? 13'h0 : tx_cnt + 13'h1;
      if (tx_load) begin
        tx_state <= uart_channel_pkg::TX_START;  // see R1, R2
        tx_shift <= tx_holding_reg;
        tx_cnt   <= 13'h0;
        tx_busy  <= 1'b1;
      end else if (tx_bit_end) begin
        case (tx_state)
          uart_channel_pkg::TX_START: begin
            tx_state <= uart_channel_pkg::TX_DATA;
            tx_bit   <= 3'h0;
          end
          uart_channel_pkg::TX_DATA: begin
            if (tx_bit == (frame_config_reg.char_length ? 3'h7 : 3'h6))
              tx_state <= frame_config_reg.parity_enable ?
                          uart_channel_pkg::TX_PARITY :
                          uart_channel_pkg::TX_STOP;
            tx_bit <= tx_bit + 3'h1;
            tx_stop2 <= 1'b0;
          end
          uart_channel_pkg::TX_PARITY: begin
            tx_state <= uart_channel_pkg::TX_STOP;
            tx_stop2 <= 1'b0;
          end
          uart_channel_pkg::TX_STOP: begin
            if (frame_config_reg.stop_bits && !tx_stop2) begin
              tx_stop2 <= 1'b1;
            end else begin
              tx_state <= uart_channel_pkg::TX_IDLE;  // see R3
              tx_busy  <= 1'b0;
            end
          end
          default: tx_state <= uart_channel_pkg::TX_IDLE;
        endcase
      end
    end
  end

  always_comb begin
    case (tx_state)
      uart_channel_pkg::TX_START:  tx_level = 1'b0;  // see R2
      uart_channel_pkg::TX_DATA:   tx_level = tx_shift[tx_bit];
      uart_channel_pkg::TX_PARITY: tx_level = tx_parity;
      default:                     tx_level = 1'b1;
    endcase
  end

  // Infrared mode sends a short inverted pulse per low bit    see R9, R10
  always_ff @(posedge clk) begin
    if (rst)
      serial_out <= 1'b1;
    else if (ce) begin
      if (frame_config_reg.infrared_mode && channel_enable)
        serial_out <= (~tx_level & (tx_cnt < ir_pulse_len)) ^
                      frame_config_reg.ir_tx_invert;
      else
        serial_out <= tx_level | ~channel_enable;  // see R27
    end
  end

  // --------------------------------------------------------------------
  // Infrared demodulator
  // --------------------------------------------------------------------
  logic        ir_in;
  logic [1:0]  ir_low_cnt;
  logic [12:0] ir_stretch;
  logic        rx_line;

  // Input invert ahead of demodulation                         see R11
  assign ir_in = serial_in ^ frame_config_reg.ir_rx_invert;

  // Low pulse shorter than the minimum is ignored              see R12
  always_ff @(posedge clk) begin
    if (srst || !channel_enable) begin
      ir_low_cnt <= 2'h0;
      ir_stretch <= 13'h0;
    end else if (op_tick) begin
      ir_low_cnt <= ir_in ? 2'h0 :
                    (ir_low_cnt == `IR_MIN_LOW_TICKS) ? ir_low_cnt :
                    ir_low_cnt + 2'h1;
      if (!ir_in && ir_low_cnt == `IR_MIN_LOW_TICKS - 2'h1)
        ir_stretch <= bit_len - 13'h3;  // see R11
      else if (ir_stretch != 13'h0)
        ir_stretch <= ir_stretch - 13'h1;
    end
  end

  assign rx_line = frame_config_reg.infrared_mode ?
                   (ir_stretch == 13'h0) : serial_in;  // see R9

  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  uart_channel_pkg::rx_state_t rx_state;
  logic [12:0] rx_cnt;
  logic [2:0]  rx_bit;
  logic        rx_par_bad;
  logic        rx_sample;

  // Sample point at mid-bit                                    see R26
  assign rx_sample = op_tick & (rx_cnt == rx_mid);

  always_ff @(posedge clk) begin
    if (srst || !channel_enable) begin  // see R27
      rx_state   <= uart_channel_pkg::RX_IDLE;
      rx_cnt     <= 13'h0;
      rx_bit     <= 3'h0;
      rx_shift   <= 8'h00;
      rx_par_bad <= 1'b0;
      rx_busy    <= 1'b0;
      rx_store   <= 1'b0;
      rx_fe      <= 1'b0;
      rx_pe      <= 1'b0;
    end else if (ce) begin
      rx_store <= 1'b0;
      if (op_tick) begin
        rx_cnt <= (rx_cnt == bit_len - 13'h1) ? 13'h0 : rx_cnt + 13'h1;
        case (rx_state)
          uart_channel_pkg::RX_IDLE: begin
            rx_cnt <= 13'h0;
            if (!rx_line) begin
              rx_state <= uart_channel_pkg::RX_START;  // see R5
              rx_busy  <= 1'b1;
              rx_cnt   <= 13'h1;
            end
          end
          uart_channel_pkg::RX_START: if (rx_sample) begin
            if (rx_line) begin
              rx_state <= uart_channel_pkg::RX_IDLE;  // see R26
              rx_busy  <= 1'b0;
            end else begin
              rx_state   <= uart_channel_pkg::RX_DATA;
              rx_bit     <= 3'h0;
              rx_shift   <= 8'h00;
              rx_par_bad <= frame_config_reg.parity_odd;
            end
          end
          uart_channel_pkg::RX_DATA: if (rx_sample) begin
            rx_shift[rx_bit] <= rx_line;  // see R5, R22
            rx_par_bad <= rx_par_bad ^ rx_line;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == (frame_config_reg.char_length ? 3'h7 : 3'h6))
              rx_state <= frame_config_reg.parity_enable ?
                          uart_channel_pkg::RX_PARITY :
                          uart_channel_pkg::RX_STOP;
          end
          uart_channel_pkg::RX_PARITY: if (rx_sample) begin
            rx_par_bad <= rx_par_bad ^ rx_line;  // see R15
            rx_state   <= uart_channel_pkg::RX_STOP;
          end
          uart_channel_pkg::RX_STOP: if (rx_sample) begin
            rx_state <= uart_channel_pkg::RX_IDLE;  // see R6
            rx_busy  <= 1'b0;
            rx_store <= 1'b1;
            rx_fe    <= ~rx_line;  // see R13
            rx_pe    <= frame_config_reg.parity_enable & rx_par_bad;
          end
          default: rx_state <= uart_channel_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Receive FIFO and error flags
  // --------------------------------------------------------------------
  logic push;
  logic fe_set;
  logic pe_set;
  uart_channel_pkg::rx_entry_t new_entry;

  assign new_entry = '{data: rx_shift, framing_err: rx_fe, parity_err: rx_pe};
  assign push = rx_store & (fifo_count != 2'd2);  // see R16
  // Error becomes visible when its byte reaches the head       see R14
  assign fe_set = (push & rx_fe & (fifo_count == 2'd0 ||
                   (fifo_count == 2'd1 && rx_pop))) |
                  (rx_pop & (fifo_count == 2'd2) & fifo[1].framing_err);
  assign pe_set = (push & rx_pe & (fifo_count == 2'd0 ||
                   (fifo_count == 2'd1 && rx_pop))) |
                  (rx_pop & (fifo_count == 2'd2) & fifo[1].parity_err);

  always_ff @(posedge clk) begin
    if (srst) begin
      fifo_count <= 2'd0;
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else if (ce) begin
      if (rx_pop)
        fifo[0] <= (fifo_count == 2'd2) ? fifo[1] : new_entry;
      case ({push, rx_pop})
        2'b10: begin
          fifo[fifo_count[0]] <= new_entry;  // see R7
          fifo_count <= fifo_count + 2'd1;
        end
        2'b11: if (fifo_count == 2'd2) fifo[1] <= new_entry;
        2'b01: fifo_count <= fifo_count - 2'd1;
        default: ;
      endcase
    end
  end

  // Set wins over clear on every flag                      see R13, R15, R18
  always_ff @(posedge clk) begin
    if (srst) begin
      framing_err_flag <= 1'b0;
      parity_err_flag  <= 1'b0;
    end else if (ce) begin
      framing_err_flag <= fe_set | (framing_err_flag &
        ~(flag_write & pwdata[`FE_BIT]) & ~(rx_pop & fifo[0].framing_err));
      parity_err_flag <= pe_set | (parity_err_flag &
        ~(flag_write & pwdata[`PE_BIT]) & ~(rx_pop & fifo[0].parity_err));
    end
  end

  // Done and overrun flags clear only by write 1 or reset     see R17
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_done_flag     <= 1'b0;
      overrun_err_flag <= 1'b0;
    end else if (ce) begin
      tx_done_flag <= (tx_busy & tx_bit_end & ~tx_load &  // see R3
                       tx_state == uart_channel_pkg::TX_STOP &&
                       (!frame_config_reg.stop_bits || tx_stop2)) |
                      (tx_done_flag & ~(flag_write & pwdata[`TEND_BIT]));
      overrun_err_flag <= (rx_store & (fifo_count == 2'd2)) |  // see R16
                          (overrun_err_flag & ~(flag_write & pwdata[`OE_BIT]));
    end
  end

  // --------------------------------------------------------------------
  // Interrupt request
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst)
      irq <= 1'b0;
    else if (ce)
      irq <= |(flag_view[6:0] & irq_enable_reg);  // see R19, R20
  end

endmodule

/* File: hdl/uart_channel_regs.svh */
`ifndef UART_CHANNEL_REGS_SVH
`define UART_CHANNEL_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLOCK_SELECT_OFS   8'h00
`define FRAME_CONFIG_OFS   8'h04
`define BIT_RATE_OFS       8'h08
`define CHANNEL_CTRL_OFS   8'h0c
`define TX_HOLDING_OFS     8'h10
`define RX_FIFO_OFS        8'h14
`define FLAG_OFS           8'h18
`define IRQ_ENABLE_OFS     8'h1c

// ----------------------------------------------------------------------
// Flag and enable bit positions
// ----------------------------------------------------------------------
`define TBE_BIT    0
`define RB1_BIT    1
`define RB2_BIT    2
`define OE_BIT     3
`define PE_BIT     4
`define FE_BIT     5
`define TEND_BIT   6
`define TX_BUSY_BIT   8
`define RX_BUSY_BIT   9

// ----------------------------------------------------------------------
// Control bit positions, reset values and infrared minimum low ticks
// ----------------------------------------------------------------------
`define CHANNEL_ENABLE_BIT 0
`define SOFT_RESET_BIT     1
`define CLOCK_SELECT_RST   9'h000
`define FRAME_CONFIG_RST   10'h000
`define BIT_RATE_RST       12'h000
`define TX_BUFFER_EMPTY_RST 1'b1
`define IR_MIN_LOW_TICKS   2'h3

`endif

/* File: hdl/uart_channel_pkg.sv */
package uart_channel_pkg;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP   = 3'b100
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic ir_rx_invert;
    logic ir_tx_invert;
    logic unused_7;
    logic input_pullup_en;
    logic output_open_drain;
    logic infrared_mode;
    logic char_length;
    logic parity_enable;
    logic parity_odd;
    logic stop_bits;
  } frame_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic       framing_err;
    logic       parity_err;
  } rx_entry_t;

endpackage

/* File: tb/uart_channel_checker.sv */
`timescale 1ns/1ps
module uart_channel_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        serial_out,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Bus answer and line and irq state after reset
  // ----------------------------------------------------------------
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held over one cycle");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access)
    else $error("pready outside an access");
  property p_one_wait; psel && !penable |=> !pready ##1 pready; endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("access not answered after one wait");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("prdata nonzero outside answer");
  property p_unmapped; pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  property p_mapped;
    pready && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
  property p_reset_idle; $fell(rst) |-> serial_out && !irq; endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("line or irq wrong after reset");
  c_read: cover property (pready && !pslverr && prdata != 32'h0);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule
bind uart_channel_core uart_channel_checker u_chk (.clk(clk), .rst(rst),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_out(serial_out), .irq(irq));

/* File: tb/uart_far_end.sv */
`timescale 1ns/1ps
module uart_far_end #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic line_in,
  output logic     line_out
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial line_out = 1'b1;
  // Frame: start low, data lsb first, chosen stop level, then idle
  task automatic send(input logic [7:0] b, input logic stp);
    logic [10:0] f;
    f = {1'b1, stp, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask
  // Mid-bit capture of what the block sends
  always @(negedge line_in) begin
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      sh[i] = line_in;
    end
    repeat (BIT_CYC) @(posedge clk);
    if (line_in === 1'b1) got.push_back(sh);
  end
endmodule

/* File: tb/uart_channel_core_bench.sv */
`timescale 1ns/1ps
`include "uart_channel_regs.svh"
module uart_channel_core_bench;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, serial_in, serial_out, irq;
  int          fails = 0, checks = 0;
  always #50 clk = ~clk;
  uart_channel_core u_dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in(serial_in), .serial_out(serial_out), .irq(irq));
  uart_far_end #(.BIT_CYC(16)) u_far (.clk(clk), .line_in(serial_out),
    .line_out(serial_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus transfer; read data is compared only on reads
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] eq,
                      input logic ee, input logic cmp = 1'b1);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      tally_and_finish();
    end
    rd_q = prdata;
    if (!w && cmp) check(prdata, eq);
    check(32'(pslverr), 32'(ee));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag(input int b, input logic v);
    for (int n = 0; n < 300; n++) begin
      xfer(1'b0, `FLAG_OFS, 32'h0, 32'h0, 1'b0, 1'b0);
      if (rd_q[b] === v) return;
    end
    fails++;
    tally_and_finish();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h001, 1'b0);
    xfer(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
    check(32'(irq), 32'h0);
  endtask
  task automatic t_tx();
    xfer(1'b1, `FRAME_CONFIG_OFS, 32'h008, 32'h0, 1'b0);
    xfer(1'b1, `BIT_RATE_OFS, 32'h0, 32'h0, 1'b0);
    xfer(1'b1, `CHANNEL_CTRL_OFS, 32'h2, 32'h0, 1'b0);
    xfer(1'b1, `CHANNEL_CTRL_OFS, 32'h1, 32'h0, 1'b0);
    xfer(1'b0, `CHANNEL_CTRL_OFS, 32'h0, 32'h1, 1'b0);
    xfer(1'b1, `TX_HOLDING_OFS, 32'ha5, 32'h0, 1'b0);
    wait_flag(`TBE_BIT, 1'b1);
    xfer(1'b1, `TX_HOLDING_OFS, 32'h3c, 32'h0, 1'b0);
    wait_flag(`TX_BUSY_BIT, 1'b0);
    check(32'(u_far.got[0]), 32'ha5);
    check(32'(u_far.got[1]), 32'h3c);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h041, 1'b0);
    xfer(1'b1, `FLAG_OFS, 32'h040, 32'h0, 1'b0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h001, 1'b0);
  endtask
  task automatic t_rx();
    u_far.send(8'h11, 1'b1);
    u_far.send(8'h22, 1'b1);
    u_far.send(8'h33, 1'b1);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h00f, 1'b0);
    xfer(1'b0, `RX_FIFO_OFS, 32'h0, 32'h11, 1'b0);
    xfer(1'b0, `RX_FIFO_OFS, 32'h0, 32'h22, 1'b0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h009, 1'b0);
    u_far.send(8'h44, 1'b0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h02b, 1'b0);
    xfer(1'b1, `IRQ_ENABLE_OFS, 32'h008, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    xfer(1'b0, `RX_FIFO_OFS, 32'h0, 32'h44, 1'b0);
    xfer(1'b1, `FLAG_OFS, 32'h008, 32'h0, 1'b0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h001, 1'b0);
    u_far.send(8'h55, 1'b1);
    u_far.send(8'h66, 1'b0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h007, 1'b0);
    xfer(1'b0, `RX_FIFO_OFS, 32'h0, 32'h55, 1'b0);
    xfer(1'b0, `FLAG_OFS, 32'h0, 32'h023, 1'b0);
  endtask
  task automatic t_ir();
    int n;
    xfer(1'b1, `CHANNEL_CTRL_OFS, 32'h0, 32'h0, 1'b0);
    xfer(1'b1, `FRAME_CONFIG_OFS, 32'h018, 32'h0, 1'b0);
    xfer(1'b1, `CHANNEL_CTRL_OFS, 32'h1, 32'h0, 1'b0);
    xfer(1'b1, `TX_HOLDING_OFS, 32'h0, 32'h0, 1'b0);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      n += serial_out;
    end
    check(n, 27);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_tx();
    t_rx();
    t_ir();
    tally_and_finish();
  end
endmodule
